// ==== src/tcsp_pkg.sv ====
package tcsp_pkg;
   // clock rate of mclk
   localparam int unsigned CLK_MHZ = 125;
   localparam int CNT_W = 27;

   // link limits the host keeps
   localparam int unsigned SCK_MAX_KHZ = 1500;
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned CMD_SPACE_US = 50;

   // ready_release_delay bounds
   localparam int unsigned REL_MIN_NS = 1000;
   localparam int unsigned REL_MAX_US = 1000;
   localparam int unsigned REL_CYC = (REL_MIN_NS * CLK_MHZ + 999) / 1000;

   // reply_byte_spacing bounds
   localparam int unsigned GAP_MIN_US = 15;
   localparam int unsigned GAP_MAX_US = 2000;
   localparam int unsigned GAP_CYC = GAP_MIN_US * CLK_MHZ;

   // command_response_delay per command class
   localparam int unsigned PUT1_MS = 10;
   localparam int unsigned PUT8_MS = 40;
   localparam int unsigned PUT64_MS = 300;
   localparam int unsigned LOCK_MS = 800;
   localparam int unsigned KEYQ_SHORT_US = 1000;
   localparam int unsigned KEYQ_LONG_US = 800;
   localparam int unsigned PUT1_CYC = PUT1_MS * 1000 * CLK_MHZ;
   localparam int unsigned PUT8_CYC = PUT8_MS * 1000 * CLK_MHZ;
   localparam int unsigned PUT64_CYC = PUT64_MS * 1000 * CLK_MHZ;
   localparam int unsigned LOCK_CYC = LOCK_MS * 1000 * CLK_MHZ;
   localparam int unsigned KEYQS_CYC = KEYQ_SHORT_US * CLK_MHZ;
   localparam int unsigned KEYQL_CYC = KEYQ_LONG_US * CLK_MHZ;

   // reset values
   localparam logic [7:0] TX_RST = 8'h00;
   // sync chain order is select, strap, toggle: select idles high, the
   // strap and the toggle start low so no false byte or mode follows reset
   localparam logic [2:0] SYNC_RST = 3'h4;

   // delay class that the core attaches to a reply
   typedef enum logic [2:0] {
      DLY_FAST,
      DLY_PUT1,
      DLY_PUT8,
      DLY_PUT64,
      DLY_LOCK,
      DLY_KEYQ
   } tcsp_dly_t;

   // port sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT,
      ST_LOAD,
      ST_READY,
      ST_RELEASE,
      ST_SSWAIT,
      ST_GAP
   } tcsp_state_t;
endpackage

// ==== src/tcsp_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcsp_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // two flops; the first one feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== src/tcsp_link.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcsp_link (
   // link clock and frame
   input wire logic sck,
   input wire logic ssN,
   input wire logic srst,
   // serial data
   input wire logic mosi,
   output logic miso,
   // byte side, quasi-static across the crossing
   input wire logic [7:0] txByte,
   output logic [7:0] rxByte,
   output logic rxToggle
);
   logic [2:0] bitCnt_r;
   logic [6:0] rxSh_r;
   logic [2:0] outIdx_r;
   logic byteEnd;

   assign byteEnd = (bitCnt_r == 3'h7);

   // sample mosi on rising sck; frame end clears the count
   always_ff @(posedge sck or posedge ssN) begin
      if (ssN) begin
         bitCnt_r <= 3'h0;
         rxSh_r <= 7'h00;
      end else begin
         bitCnt_r <= bitCnt_r + 3'h1;
         rxSh_r <= {rxSh_r[5:0], mosi};
      end
   end

   // whole byte plus toggle event for the mclk side
   always_ff @(posedge sck or posedge srst) begin
      if (srst) begin
         rxByte <= 8'h00;
         rxToggle <= 1'b0;
      end else if (!ssN && byteEnd) begin
         rxByte <= {rxSh_r, mosi};
         rxToggle <= ~rxToggle;
      end
   end

   // next bit index moves on falling sck, msb sits ready before the first rise
   always_ff @(negedge sck or posedge ssN) begin
      if (ssN) begin
         outIdx_r <= 3'h0;
      end else begin
         outIdx_r <= outIdx_r + 3'h1;
      end
   end

   // txByte is held stable by the sequencer while ssN is low
   assign miso = txByte[~outIdx_r];
endmodule
`default_nettype wire

// ==== src/tcsp_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcsp_port #(
   parameter int unsigned PUT1_CYC = tcsp_pkg::PUT1_CYC,
   parameter int unsigned PUT8_CYC = tcsp_pkg::PUT8_CYC,
   parameter int unsigned PUT64_CYC = tcsp_pkg::PUT64_CYC,
   parameter int unsigned LOCK_CYC = tcsp_pkg::LOCK_CYC
) (
   // system clock and reset
   input wire logic mclk,
   input wire logic srst,
   // link pins
   input wire logic sck,
   input wire logic ssN,
   input wire logic mosi,
   output logic miso,
   output logic misoOe,
   output logic drdyN,
   // strap
   input wire logic portModeSelect,
   output logic slaveOnly,
   // command bytes toward the core
   output logic cmdStrobe,
   output logic [7:0] cmdData,
   // reply bytes from the core
   input wire logic replyLoad,
   input wire logic [7:0] replyByte,
   input wire logic replyLast,
   input wire tcsp_pkg::tcsp_dly_t replyClass,
   input wire logic burstShort,
   output logic replyFull
);
   localparam int CW = tcsp_pkg::CNT_W;

   // link domain wires
   logic [7:0] rxByte;
   logic rxToggle;
   logic linkMiso;

   // synchronised pins
   logic [2:0] syncIn;
   logic [2:0] syncOut;
   logic ssHigh;
   logic modeHigh;
   logic rxTglS;
   logic rxTglD_r;
   logic rxEvt;

   // sequencer state
   tcsp_pkg::tcsp_state_t st_r;
   tcsp_pkg::tcsp_state_t st_nxt;
   logic [CW-1:0] cnt_r;
   logic clrCnt;
   logic cntSat;

   // pending reply from the core
   logic pendValid_r;
   logic [7:0] pendByte_r;
   logic pendLast_r;
   tcsp_pkg::tcsp_dly_t pendClass_r;
   logic takeReply;
   logic dropReply;

   // byte on the shifter
   logic [7:0] txHold_r;
   logic lastHold_r;

   // output flops
   logic drdyN_r;
   logic drdyN_nxt;
   logic cmdStrobe_r;
   logic [7:0] cmdData_r;
   logic slaveOnly_r;

   // delay limits
   logic [CW-1:0] keyqLim;
   logic [CW-1:0] respLim;
   logic respDue;
   logic relDue;
   logic gapDue;
   logic newCmd;
   logic frameIdle;
   logic passive;

   // link side shifter on its own clock; the byte toggle and select cross back
   // through flops, rxByte is read after its toggle, and the held byte is rewritten by mclk only while select
   // has been seen high, so the shifter never reads a word mid-change
   tcsp_link u_link (
      .sck(sck),
      .ssN(ssN),
      .srst(srst),
      .mosi(mosi),
      .miso(linkMiso),
      .txByte(txHold_r),
      .rxByte(rxByte),
      .rxToggle(rxToggle)
   );

   // pins and the byte toggle cross into mclk
   assign syncIn = {ssN, portModeSelect, rxToggle};

   tcsp_sync #(
      .W(3),
      .RST_VAL(tcsp_pkg::SYNC_RST)
   ) u_sync (
      .clk(mclk),
      .rst(srst),
      .d(syncIn),
      .q(syncOut)
   );

   assign ssHigh = syncOut[2];
   assign modeHigh = syncOut[1];
   assign rxTglS = syncOut[0];

   // edge of the toggle marks one finished byte; the delayed copy resets
   // to the same low level as the chain, so no false byte follows reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         rxTglD_r <= 1'b0;
      end else begin
         rxTglD_r <= rxTglS;
      end
   end

   assign rxEvt = rxTglS ^ rxTglD_r;

   // only slave-only is built; a low strap parks the port.
   // the master clock rate setup belongs to the master port.
   always_ff @(posedge mclk) begin
      if (srst) begin
         slaveOnly_r <= 1'b0;
      end else begin
         slaveOnly_r <= modeHigh;
      end
   end

   // host byte counts as a command only outside a reply; bytes that land
   // while a reply is open are fetches or noise and are not passed on
   assign newCmd = rxEvt && slaveOnly_r &&
                   (st_r == tcsp_pkg::ST_IDLE || st_r == tcsp_pkg::ST_WAIT);

   // delay limit per class; the key queries take theirs from the burst
   // spacing that the core reports
   assign keyqLim = burstShort ? CW'(tcsp_pkg::KEYQS_CYC) :
                                 CW'(tcsp_pkg::KEYQL_CYC);
   always_comb begin
      case (pendClass_r)
         tcsp_pkg::DLY_PUT1: respLim = CW'(PUT1_CYC);
         tcsp_pkg::DLY_PUT8: respLim = CW'(PUT8_CYC);
         tcsp_pkg::DLY_PUT64: respLim = CW'(PUT64_CYC);
         tcsp_pkg::DLY_LOCK: respLim = CW'(LOCK_CYC);
         tcsp_pkg::DLY_KEYQ: respLim = keyqLim;
         default: respLim = {CW{1'b0}};
      endcase
   end

   assign respDue = pendValid_r && (cnt_r >= respLim);
   assign relDue = (cnt_r >= CW'(tcsp_pkg::REL_CYC));
   assign gapDue = pendValid_r && (cnt_r >= CW'(tcsp_pkg::GAP_CYC));
   assign cntSat = &cnt_r;

   // ready may only fall while no host frame is open, so a byte being
   // received never sees the line change under it
   assign frameIdle = ssHigh;

   // a strap that reads low parks the sequencer and empties the slot
   assign passive = !slaveOnly_r;

   // sequencer next state
   always_comb begin
      st_nxt = st_r;
      clrCnt = 1'b0;
      case (st_r)
         tcsp_pkg::ST_IDLE: begin
            if (newCmd) begin
               st_nxt = tcsp_pkg::ST_WAIT;
               clrCnt = 1'b1;
            end
         end
         tcsp_pkg::ST_WAIT: begin
            // silence from the core keeps ready high for good
            if (newCmd) begin
               clrCnt = 1'b1;
            end else if (respDue && frameIdle) begin
               st_nxt = tcsp_pkg::ST_LOAD;
            end
         end
         tcsp_pkg::ST_LOAD: begin
            // shifter is written this cycle, ready falls on the next edge
            st_nxt = tcsp_pkg::ST_READY;
         end
         tcsp_pkg::ST_READY: begin
            // the dummy byte of the fetch completes the reply byte
            if (rxEvt) begin
               st_nxt = tcsp_pkg::ST_RELEASE;
               clrCnt = 1'b1;
            end
         end
         tcsp_pkg::ST_RELEASE: begin
            // ready stays low for the release time after the fetched byte
            if (relDue) begin
               st_nxt = tcsp_pkg::ST_SSWAIT;
            end
         end
         tcsp_pkg::ST_SSWAIT: begin
            // the next byte waits until select is seen high again
            if (ssHigh) begin
               st_nxt = lastHold_r ? tcsp_pkg::ST_IDLE : tcsp_pkg::ST_GAP;
               clrCnt = 1'b1;
            end
         end
         tcsp_pkg::ST_GAP: begin
            if (gapDue && frameIdle) begin
               st_nxt = tcsp_pkg::ST_LOAD;
            end
         end
         default: begin
            st_nxt = tcsp_pkg::ST_IDLE;
         end
      endcase
      // a low strap wins over whatever step the case chose, so a strap
      // that drops mid-reply cannot leave ready hanging low
      if (passive) begin
         st_nxt = tcsp_pkg::ST_IDLE;
         clrCnt = 1'b1;
      end
   end

   // ready is low only while a loaded byte waits or is being finished;
   // taken from the next state so the pin moves on the same edge as it
   assign drdyN_nxt = !(st_nxt == tcsp_pkg::ST_READY ||
                        st_nxt == tcsp_pkg::ST_RELEASE);

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r <= tcsp_pkg::ST_IDLE;
         drdyN_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         drdyN_r <= drdyN_nxt;
      end
   end

   // one timer serves every delay; saturates so long waits stay due.
   // each wait counts from whatever cleared it last: the command byte,
   // the fetched byte or select seen high
   always_ff @(posedge mclk) begin
      if (srst || clrCnt) begin
         cnt_r <= {CW{1'b0}};
      end else if (!cntSat) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // pending slot: a load in the same cycle as a drop wins, so a byte the
   // core offers is never lost to a command landing in that cycle
   assign takeReply = replyLoad && !pendValid_r;
   assign dropReply = newCmd || passive || (st_r == tcsp_pkg::ST_LOAD);

   always_ff @(posedge mclk) begin
      if (srst) begin
         pendValid_r <= 1'b0;
      end else if (takeReply) begin
         pendValid_r <= 1'b1;
      end else if (dropReply) begin
         pendValid_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pendByte_r <= tcsp_pkg::TX_RST;
         pendLast_r <= 1'b1;
         pendClass_r <= tcsp_pkg::DLY_FAST;
      end else if (takeReply) begin
         pendByte_r <= replyByte;
         pendLast_r <= replyLast;
         pendClass_r <= replyClass;
      end
   end

   // shifter content changes only in LOAD, never inside a frame
   always_ff @(posedge mclk) begin
      if (srst) begin
         txHold_r <= tcsp_pkg::TX_RST;
         lastHold_r <= 1'b1;
      end else if (st_r == tcsp_pkg::ST_LOAD) begin
         txHold_r <= pendByte_r;
         lastHold_r <= pendLast_r;
      end
   end

   // command byte handed to the core; rxByte is read about three mclk
   // after its toggle, long after the last sck edge wrote it
   always_ff @(posedge mclk) begin
      if (srst) begin
         cmdStrobe_r <= 1'b0;
         cmdData_r <= 8'h00;
      end else begin
         cmdStrobe_r <= newCmd;
         if (newCmd) begin
            cmdData_r <= rxByte;
         end
      end
   end

   // pin drive; miso follows select directly so the first bit is in time.
   // the enable skips the flops too: a synchronised copy would come after
   // the first sck rise could already need the line
   assign miso = linkMiso;
   assign misoOe = !ssN;
   assign drdyN = drdyN_r;
   assign slaveOnly = slaveOnly_r;
   assign cmdStrobe = cmdStrobe_r;
   assign cmdData = cmdData_r;
   assign replyFull = pendValid_r;
endmodule
`default_nettype wire

// ==== tb/tcsp_port_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcsp_port_sva (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // link side
   input wire logic ssN,
   input wire logic misoOe,
   input wire logic drdyN,
   input wire logic slaveOnly,
   // core side
   input wire logic cmdStrobe,
   input wire logic replyLoad,
   input wire logic replyFull
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // the slot must empty as ready drops
   sequence slot_gone_s;
      $past(replyFull) && !replyFull;
   endsequence
   // shared line left alone while deselected
   miso_drive_a: assert property (misoOe == !ssN)
      else $error("miso enable off select");
   ready_passive_a: assert property (!slaveOnly |-> drdyN)
      else $error("ready low while passive");
   load_first_a: assert property ($fell(drdyN) |-> slot_gone_s)
      else $error("ready fell with no loaded byte");
   release_min_a: assert property ($rose(drdyN) |-> !$past(drdyN, 100))
      else $error("ready released too early");
   frame_hold_a: assert property (!ssN && drdyN |=> drdyN)
      else $error("ready fell inside a frame");
   strobe_pulse_a: assert property (cmdStrobe |=> !cmdStrobe)
      else $error("command strobe too long");
   slot_take_a: assert property (replyLoad && !replyFull |=> replyFull)
      else $error("offered byte not taken");
   slot_quiet_a: assert property (!replyFull && !replyLoad |=> !replyFull)
      else $error("slot filled unprompted");
endmodule
bind tcsp_port tcsp_port_sva tcsp_port_sva_i (.mclk(mclk), .srst(srst), .ssN(ssN),
   .misoOe(misoOe), .drdyN(drdyN), .slaveOnly(slaveOnly), .cmdStrobe(cmdStrobe),
   .replyLoad(replyLoad), .replyFull(replyFull));
`default_nettype wire

// ==== tb/tcsp_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcsp_host (
   // link pins driven
   output logic sck,
   output logic ssN,
   output logic mosi,
   // link pins read
   input wire logic miso,
   input wire logic drdyN
);
   // idle: clock low, deselected
   initial begin
      sck = 1'h0;
      ssN = 1'h1;
      mosi = 1'h0;
   end
   // one byte msb first; w counts 8 ns waits for ready release
   task automatic xfer(input logic [7:0] tx, input logic hold, output logic [7:0] rx,
         output int w);
      w = 0;
      ssN = 1'h0;
      #10;
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #3 sck = 1'h1;
         rx[i] = miso;
         #3 sck = 1'h0;
      end
      mosi = ~mosi; // inverted last bit, no stale value
      #10;
      while (hold && drdyN !== 1'h1 && w < 2000) begin
         #8 w++;
      end
      ssN = 1'h1;
      if (!hold) #50000;
   endtask
endmodule
`default_nettype wire

// ==== tb/tcsp_port_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcsp_port_tb_top;
   logic mclk, srst, sck, ssN, mosi, miso, misoOe, drdyN, portModeSelect, slaveOnly;
   logic cmdStrobe, replyLoad, replyLast, burstShort, replyFull;
   logic [7:0] cmdData, replyByte, rx;
   tcsp_pkg::tcsp_dly_t replyClass;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   int ts, tf;
   // counts are shortened so the run stays brief
   tcsp_port #(.PUT1_CYC(200), .PUT8_CYC(400), .PUT64_CYC(600), .LOCK_CYC(800)) tcsp_port_i (
      .mclk(mclk), .srst(srst), .sck(sck), .ssN(ssN), .mosi(mosi), .miso(miso),
      .misoOe(misoOe), .drdyN(drdyN), .portModeSelect(portModeSelect),
      .slaveOnly(slaveOnly), .cmdStrobe(cmdStrobe), .cmdData(cmdData),
      .replyLoad(replyLoad), .replyByte(replyByte), .replyLast(replyLast),
      .replyClass(replyClass), .burstShort(burstShort), .replyFull(replyFull));
   tcsp_host tcsp_host_i (.sck(sck), .ssN(ssN), .mosi(mosi), .miso(miso), .drdyN(drdyN));
   // system clock and cycle count
   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // sel 0 waits for a strobe, 1 for ready low; t stays -1 on timeout
   task automatic wait_sig(input int sel, input int lim, output int t);
      t = -1;
      for (int n = 0; n < lim && t < 0; n++) begin
         @(posedge mclk);
         #1;
         if ((sel == 0 && cmdStrobe === 1'h1) || (sel == 1 && drdyN === 1'h0)) t = cyc;
      end
   endtask
   task automatic load(input logic [7:0] b, input tcsp_pkg::tcsp_dly_t c, input logic l);
      @(posedge mclk);
      replyLoad <= 1'h1;
      replyByte <= b;
      replyClass <= c;
      replyLast <= l;
      @(posedge mclk);
      replyLoad <= 1'h0;
      #1 check("slot full", replyFull, 1'h1);
   endtask
   // a command byte; the core answers with its inverse when ld is set
   task automatic cmd(input logic [7:0] b, input logic ld, input tcsp_pkg::tcsp_dly_t c,
         input logic l);
      int w;
      tf = -1;
      // select must be seen high before the next frame opens
      #100;
      fork
         tcsp_host_i.xfer(b, 1'h0, rx, w);
         begin
            wait_sig(0, 100, ts);
            if (ld) begin
               load(b ^ 8'hFF, c, l);
               wait_sig(1, 2000, tf);
            end
         end
      join
   endtask
   task automatic fetch(input logic [7:0] exp);
      int w;
      tcsp_host_i.xfer(8'h00, 1'h1, rx, w);
      check("reply byte", rx, exp);
      check("release delay", w >= 124 && w < 2000, 1'h1);
   endtask
   task automatic t_strap;
      cmd(8'h3C, 1'h0, tcsp_pkg::DLY_FAST, 1'h0);
      check("strobe when passive", ts < 0, 1'h1);
      @(posedge mclk);
      portModeSelect <= 1'h1;
      repeat (6) @(posedge mclk);
      #1;
      check("slave only", slaveOnly, 1'h1);
      cmd(8'hA5, 1'h0, tcsp_pkg::DLY_FAST, 1'h0);
      check("command byte", cmdData, 8'hA5);
      check("unanswered ready", drdyN, 1'h1);
   endtask
   task automatic t_replies;
      tcsp_pkg::tcsp_dly_t cl [5];
      int lm [5];
      cl = '{tcsp_pkg::DLY_FAST, tcsp_pkg::DLY_PUT1, tcsp_pkg::DLY_PUT8,
         tcsp_pkg::DLY_PUT64, tcsp_pkg::DLY_LOCK};
      lm = '{0, 200, 400, 600, 800};
      for (int i = 0; i < 5; i++) begin
         cmd(8'h40 + 8'(i), 1'h1, cl[i], 1'h1);
         check("reply delay", tf - ts >= lm[i] && tf - ts <= lm[i] + 10, 1'h1);
         fetch((8'h40 + 8'(i)) ^ 8'hFF);
      end
   endtask
   // two byte reply: second waits for select high plus spacing
   task automatic t_multi;
      int t;
      cmd(8'h6E, 1'h1, tcsp_pkg::DLY_FAST, 1'h0);
      load(8'h5A, tcsp_pkg::DLY_FAST, 1'h1);
      fetch(8'h91);
      t = cyc;
      wait_sig(1, 2500, tf);
      check("byte spacing", tf - t >= 1875 && tf - t <= 1900, 1'h1);
      fetch(8'h5A);
   endtask
   // key queries outlast the window; a new command drops them
   task automatic t_keyq;
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk);
         burstShort <= i[0];
         cmd(8'h4B, 1'h1, tcsp_pkg::DLY_KEYQ, 1'h1);
         check("key query ready", drdyN, 1'h1);
      end
      cmd(8'h00, 1'h0, tcsp_pkg::DLY_FAST, 1'h0);
      check("slot dropped", replyFull, 1'h0);
      check("dropped ready", drdyN, 1'h1);
   endtask
   // main sequence
   initial begin
      srst = 1'h1;
      portModeSelect = 1'h0;
      replyLoad = 1'h0;
      replyByte = 8'h00;
      replyLast = 1'h0;
      replyClass = tcsp_pkg::DLY_FAST;
      burstShort = 1'h0;
      repeat (4) @(posedge mclk);
      srst <= 1'h0;
      repeat (6) @(posedge mclk);
      #1;
      check("reset ready", drdyN, 1'h1);
      check("reset slot", replyFull, 1'h0);
      check("idle miso enable", misoOe, 1'h0);
      t_strap();
      t_replies();
      t_multi();
      t_keyq();
      finish_test();
   end
   // hang guard; the scenarios need about 72000 cycles
   initial begin
      repeat (90000) @(posedge mclk);
      fails++;
      finish_test();
   end
endmodule
`default_nettype wire
